// ---- cpu_model.sv ----
// bus master model of the servicing processor
`timescale 1ns/1ps
module cpu_model (
  input wire clk,
  output reg [7:0] s_axi_awaddr = 8'h00,
  output reg s_axi_awvalid = 1'b0,
  input wire s_axi_awready,
  output reg [31:0] s_axi_wdata = 32'h0000_0000,
  output reg [3:0] s_axi_wstrb = 4'hf,
  output reg s_axi_wvalid = 1'b0,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire [1:0] s_axi_bresp,
  output reg s_axi_bready = 1'b1,
  output reg [7:0] s_axi_araddr = 8'h00,
  output reg s_axi_arvalid = 1'b0,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  output reg s_axi_rready = 1'b1
);
  reg [1:0] bResp = 2'b00;
  // released payload is scrambled so stale values cannot pass
  task wr(input [7:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_awvalid && s_axi_awready) begin
          s_axi_awvalid <= 1'b0;
          s_axi_awaddr <= ~a;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          s_axi_wvalid <= 1'b0;
          s_axi_wdata <= ~d;
        end
      end while (!s_axi_bvalid);
      bResp = s_axi_bresp;
    end
  endtask
  task rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge clk);
        if (s_axi_arvalid && s_axi_arready) begin
          s_axi_arvalid <= 1'b0;
          s_axi_araddr <= ~a;
        end
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the uart interrupt identification block
`timescale 1ns/1ps
module tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  wire [7:0] s_axi_awaddr, s_axi_araddr, txData;
  wire [31:0] s_axi_wdata, s_axi_rdata;
  wire [3:0] s_axi_wstrb;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  wire s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rxPopReq, txWrite, uartIrq;
  reg [4:0] rxLevel = 5'h00, txLevel = 5'h01, lv;
  reg rxPush = 1'b0, rxPop = 1'b0, overrunErr = 1'b0, parityErr = 1'b0;
  reg framingErr = 1'b0, breakDet = 1'b0;
  reg [7:0] rxData = 8'h5a;
  reg [31:0] d;
  reg [1:0] r;
  integer errors = 0, total_checks = 0, cycles = 0, k;
  integer txWrites = 0, rxPops = 0;
  always #5 clk = ~clk;
  cpu_model i_cpu_model (.*);
  uart_irq_ident i_uart_irq_ident (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task id(input [3:0] e);
    begin
      cyc(2);
      i_cpu_model.rd(8'h08, d, r);
      chk({28'h0, d[3:0]}, {28'h0, e});
    end
  endtask
  task rxMove(input [4:0] n, input isPush);
    begin
      rxLevel <= n;
      rxPush <= isPush;
      rxPop <= !isPush;
      cyc(1);
      rxPush <= 1'b0;
      rxPop <= 1'b0;
    end
  endtask
  task stop_test;
    begin
      if (errors == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // strobes are counted so single pulses cannot slip past a sampled compare
  always @(posedge clk) begin
    if (txWrite) txWrites <= txWrites + 1;
    if (rxPopReq) rxPops <= rxPops + 1;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      errors = errors + 1;
      stop_test;
    end
  end
  initial begin
    cyc(10);
    rst <= 1'b0;
    id(4'h1);
    i_cpu_model.rd(8'h20, d, r);
    chk({d[31:2], r}, 32'h0000_0002);
    i_cpu_model.wr(8'h20, 32'h0000_0000);
    chk({30'h0, i_cpu_model.bResp}, 32'h0000_0002);
    i_cpu_model.wr(8'h04, 32'h0000_0007);
    chk({30'h0, i_cpu_model.bResp}, 32'h0000_0000);
    txLevel <= 5'h00;
    cyc(3);
    chk({31'h0, uartIrq}, 32'h0000_0001);
    id(4'h2);
    id(4'h1);
    chk({31'h0, uartIrq}, 32'h0000_0000);
    txLevel <= 5'h01;
    cyc(2);
    txLevel <= 5'h00;
    id(4'h2);
    i_cpu_model.wr(8'h00, 32'h0000_0041);
    id(4'h1);
    chk({24'h0, txData}, 32'h0000_0041);
    // error, data and tx empty all pending at once
    rxLevel <= 5'h01;
    parityErr <= 1'b1;
    txLevel <= 5'h01;
    cyc(1);
    parityErr <= 1'b0;
    txLevel <= 5'h00;
    id(4'h6);
    i_cpu_model.rd(8'h14, d, r);
    chk({29'h0, d[2:0]}, 32'h0000_0005);
    id(4'h4);
    i_cpu_model.rd(8'h00, d, r);
    rxLevel <= 5'h00;
    chk({24'h0, d[7:0]}, 32'h0000_005a);
    id(4'h2);
    id(4'h1);
    // fifo on, trigger 4, char time 4 clocks
    i_cpu_model.wr(8'h40, 32'h0000_0004);
    i_cpu_model.wr(8'h08, 32'h0000_0041);
    rxMove(5'h02, 1'b1);
    id(4'h1);
    cyc(16);
    id(4'hc);
    i_cpu_model.rd(8'h00, d, r);
    rxMove(5'h01, 1'b0);
    id(4'h1);
    rxMove(5'h04, 1'b1);
    id(4'h4);
    rxMove(5'h03, 1'b0);
    id(4'h1);
    rxMove(5'h00, 1'b0);
    i_cpu_model.wr(8'h04, 32'h0000_0082);
    for (k = 0; k < 4; k = k + 1) begin
      lv = (k == 0) ? 5'h00 : (5'h01 << k);
      i_cpu_model.wr(8'h08, 32'h0000_0001 | (k << 4));
      txLevel <= lv + 5'h01;
      id(4'h1);
      txLevel <= lv;
      id(4'h2);
    end
    txLevel <= 5'h10;
    cyc(2);
    i_cpu_model.rd(8'h14, d, r);
    chk({31'h0, d[5]}, 32'h0000_0001);
    i_cpu_model.wr(8'h08, 32'h0000_0010);
    id(4'h1);
    i_cpu_model.rd(8'h14, d, r);
    chk({31'h0, d[5]}, 32'h0000_0000);
    txLevel <= 5'h00;
    id(4'h2);
    i_cpu_model.rd(8'h14, d, r);
    chk({31'h0, d[5]}, 32'h0000_0001);
    chk(txWrites, 32'h0000_0001);
    chk(rxPops, 32'h0000_0002);
    stop_test;
  end
endmodule

// ---- uart_irq_ident.v ----
// uart interrupt identification, clearing and threshold mode with axi4-lite slave
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "uart_irq_regs.vh"
module uart_irq_ident (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [4:0] rxLevel,
  input wire [4:0] txLevel,
  input wire rxPush,
  input wire rxPop,
  input wire overrunErr,
  input wire parityErr,
  input wire framingErr,
  input wire breakDet,
  input wire [7:0] rxData,
  output wire rxPopReq,
  output reg [7:0] txData,
  output reg txWrite,
  output reg uartIrq
);
  reg [7:0] irqEn_r;
  reg [7:0] fifoCtrl_r;
  reg [15:0] charTime_r;
  reg lineErr_r;
  reg txPend_r;
  reg toPend_r;
  reg [15:0] tick_r;
  reg [2:0] idleChars_r;
  reg [7:0] errFlags_r;
  reg awHeld_r;
  reg wHeld_r;
  reg [7:0] awAddr_r;
  reg [31:0] wData_r;
  reg [3:0] wStrb_r;
  wire [3:0] ident;
  wire fifoOn;
  wire thrMode;
  wire rxAct;
  wire txCond;
  wire wrFire;
  wire rdFire;
  wire rdLine;
  wire rdRxBuf;
  wire rdIdent;
  wire wrHold;
  wire [7:0] lineStat;
  reg [4:0] rxTrig;
  reg [4:0] txThr;

  // fifo control trigger fields decode to fill levels
  function [4:0] rxTrigLevel;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: rxTrigLevel = 5'h01;
        2'b01: rxTrigLevel = 5'h04;
        2'b10: rxTrigLevel = 5'h08;
        default: rxTrigLevel = 5'h0e;
      endcase
    end
  endfunction

  function [4:0] txThrLevel;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: txThrLevel = 5'h00;
        2'b01: txThrLevel = 5'h02;
        2'b10: txThrLevel = `FIFO_DEPTH >> 2;
        default: txThrLevel = `FIFO_DEPTH >> 1;
      endcase
    end
  endfunction

  always @* begin
    rxTrig = rxTrigLevel(fifoCtrl_r[`FCR_RX_TRIG_HI:`FCR_RX_TRIG_LO]);
    txThr = txThrLevel(fifoCtrl_r[`FCR_TX_THR_HI:`FCR_TX_THR_LO]);
  end

  assign fifoOn = fifoCtrl_r[`FCR_FIFO_EN];
  assign thrMode = irqEn_r[`IEN_THR_MODE] & fifoOn;
  // level-driven: rx condition follows the fill directly, so it clears itself
  assign rxAct = fifoOn ? (rxLevel >= rxTrig) : (rxLevel != 5'h00);
  assign txCond = thrMode ? (txLevel <= txThr) : (txLevel == 5'h00);

  // axi4-lite write: address and data taken in either order, then one response
  assign s_axi_awready = ~awHeld_r & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld_r & ~s_axi_bvalid;
  assign wrFire = awHeld_r & wHeld_r & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rdFire = s_axi_arvalid & s_axi_arready;
  assign rdLine = rdFire & (s_axi_araddr == `OFS_LINE_STAT);
  assign rdRxBuf = rdFire & (s_axi_araddr == `OFS_RX_BUF);
  assign rdIdent = rdFire & (s_axi_araddr == `OFS_IDENT);
  assign wrHold = wrFire & (awAddr_r == `OFS_TX_HOLD) & wStrb_r[0];
  assign rxPopReq = rdRxBuf & (rxLevel != 5'h00);

  always @(posedge clk) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 32'h0000_0000;
      wStrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awAddr_r)
          `OFS_TX_HOLD, `OFS_IRQ_EN, `OFS_FIFO_CTRL, `OFS_CHAR_TIME: s_axi_bresp <= 2'b00;
          default: s_axi_bresp <= 2'b10;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  always @(posedge clk) begin
    if (rst) begin
      irqEn_r <= 8'h00;
      fifoCtrl_r <= 8'h00;
      charTime_r <= `CHAR_TIME_RST;
      txData <= 8'h00;
      txWrite <= 1'b0;
    end else begin
      txWrite <= wrHold;
      if (wrHold) begin
        txData <= wData_r[7:0];
      end
      if (wrFire & (awAddr_r == `OFS_IRQ_EN) & wStrb_r[0]) begin
        irqEn_r <= wData_r[7:0];
      end
      if (wrFire & (awAddr_r == `OFS_FIFO_CTRL) & wStrb_r[0]) begin
        fifoCtrl_r <= wData_r[7:0];
      end
      if (wrFire & (awAddr_r == `OFS_CHAR_TIME)) begin
        if (wStrb_r[0]) begin
          charTime_r[7:0] <= wData_r[7:0];
        end
        if (wStrb_r[1]) begin
          charTime_r[15:8] <= wData_r[15:8];
        end
      end
    end
  end

  // sticky line errors; a new error in the clearing cycle survives
  always @(posedge clk) begin
    if (rst) begin
      lineErr_r <= 1'b0;
      errFlags_r <= 8'h00;
    end else begin
      lineErr_r <= (lineErr_r & ~rdLine) | overrunErr | parityErr | framingErr | breakDet;
      errFlags_r <= (errFlags_r & ~{8{rdLine}}) |
        {3'b000, breakDet, framingErr, parityErr, overrunErr, 1'b0};
    end
  end

  // tx empty: set on rising condition, cleared by ident read, hold write or leaving threshold
  reg txCondD_r;
  always @(posedge clk) begin
    if (rst) begin
      txPend_r <= 1'b0;
      txCondD_r <= 1'b0;
    end else begin
      txCondD_r <= txCond;
      if (txCond & ~txCondD_r) begin
        txPend_r <= 1'b1;
      end else if (~txCond | wrHold | (rdIdent & (ident == `ID_TX))) begin
        txPend_r <= 1'b0;
      end
    end
  end

  // character timeout: tick counts one character time, four idle ones raise it
  always @(posedge clk) begin
    if (rst) begin
      tick_r <= 16'h0000;
      idleChars_r <= 3'h0;
      toPend_r <= 1'b0;
    end else if (~fifoOn | (rxLevel == 5'h00) | rxPush | rxPop) begin
      tick_r <= 16'h0000;
      idleChars_r <= 3'h0;
      if (~fifoOn | rdRxBuf | (rxLevel == 5'h00)) begin
        toPend_r <= 1'b0;
      end
    end else if (tick_r + 16'h0001 >= charTime_r) begin
      tick_r <= 16'h0000;
      // a buffer read on the wrap cycle must still clear; a fresh timeout wins
      if (rdRxBuf) begin
        toPend_r <= 1'b0;
      end
      if (idleChars_r + 3'h1 == `TIMEOUT_CHARS) begin
        toPend_r <= 1'b1;
        idleChars_r <= `TIMEOUT_CHARS;
      end else if (idleChars_r != `TIMEOUT_CHARS) begin
        idleChars_r <= idleChars_r + 3'h1;
      end
    end else begin
      tick_r <= tick_r + 16'h0001;
      if (rdRxBuf) begin
        toPend_r <= 1'b0;
      end
    end
  end

  wire lineAct = lineErr_r & irqEn_r[`IEN_LINE];
  wire rxEn = rxAct & irqEn_r[`IEN_RX];
  wire toAct = toPend_r & irqEn_r[`IEN_RX] & fifoOn;
  wire txAct = txPend_r & irqEn_r[`IEN_TX];

  uart_irq_prio prio (
    .lineAct(lineAct),
    .rxAct(rxEn),
    .toAct(toAct),
    .txAct(txAct),
    .ident(ident)
  );

  // status bit 5 reports full in threshold mode, otherwise empty
  assign lineStat = {1'b0, (txLevel == 5'h00),
    (thrMode ? (txLevel >= `FIFO_DEPTH) : (txLevel == 5'h00)),
    errFlags_r[4:1], (rxLevel != 5'h00)};

  // read channel
  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      uartIrq <= 1'b0;
    end else begin
      uartIrq <= lineAct | rxEn | toAct | txAct;
      if (rdFire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `OFS_RX_BUF: s_axi_rdata <= {24'h00_0000, rxData};
          `OFS_IRQ_EN: s_axi_rdata <= {24'h00_0000, irqEn_r};
          `OFS_IDENT: s_axi_rdata <= {24'h00_0000, {2{fifoOn}}, 2'b00, ident};
          `OFS_LINE_STAT: s_axi_rdata <= {24'h00_0000, lineStat};
          `OFS_CHAR_TIME: s_axi_rdata <= {16'h0000, charTime_r};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- uart_irq_ident_sva.sv ----
// port assertions for the uart interrupt block
`timescale 1ns/1ps
module uart_irq_ident_chk (
  input wire clk,
  input wire rst,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_rvalid,
  input wire [1:0] s_axi_rresp,
  input wire [31:0] s_axi_rdata,
  input wire rxPopReq,
  input wire txWrite
);
  reg [7:0] lastAr_r = 8'h00;
  wire identRd = lastAr_r == 8'h08;
  wire unmapped = !(lastAr_r inside {8'h00, 8'h04, 8'h08, 8'h14, 8'h40});
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always @(posedge clk)
    if (s_axi_arvalid && s_axi_arready) lastAr_r <= s_axi_araddr;
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write answer missing");
  property p_bref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bref: assert property (p_bref) else $error("write taken during response");
  property p_rref; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rref: assert property (p_rref) else $error("read taken during response");
  property p_pop; rxPopReq |-> s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00;
  endproperty
  a_pop: assert property (p_pop) else $error("pop without buffer read");
  property p_code; s_axi_rvalid && identRd
    |-> s_axi_rdata[3:0] inside {4'h1, 4'h6, 4'h4, 4'hc, 4'h2}; endproperty
  a_code: assert property (p_code) else $error("reserved ident code");
  property p_err; s_axi_rvalid && unmapped
    |-> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000; endproperty
  a_err: assert property (p_err) else $error("unmapped read not refused");
  property p_txw; txWrite |=> !txWrite; endproperty
  a_txw: assert property (p_txw) else $error("holding write pulse too long");
  c_to: cover property (s_axi_rvalid && identRd && s_axi_rdata[3:0] == 4'hc);
  c_pop: cover property (rxPopReq);
  c_tx: cover property (txWrite);
endmodule
bind uart_irq_ident uart_irq_ident_chk i_uart_irq_ident_chk (.clk(clk), .rst(rst),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .rxPopReq(rxPopReq),
  .txWrite(txWrite));

// ---- uart_irq_prio.v ----
// priority encoder from pending sources to identification code
`timescale 1ns/1ps
`include "uart_irq_regs.vh"
module uart_irq_prio (
  input wire lineAct,
  input wire rxAct,
  input wire toAct,
  input wire txAct,
  output reg [3:0] ident
);
  // only five defined codes are ever produced
  always @* begin
    if (lineAct) begin
      ident = `ID_LINE;
    end else if (rxAct) begin
      ident = `ID_RX;
    end else if (toAct) begin
      ident = `ID_TIMEOUT;
    end else if (txAct) begin
      ident = `ID_TX;
    end else begin
      ident = `ID_NONE;
    end
  end
endmodule

// ---- uart_irq_regs.vh ----
// register offsets, field positions, codes and timing counts for uart interrupt logic
// Behaviour
// - irq out when enabled source active
// - timeout only fifo; threshold only thr-mode
// - priority line, rx, timeout, tx; none 0001
// - line errors give 0110, line-status read clears
// - rx data 0100: char or trigger reached
// - rx clears on read or below trigger
// - timeout 1100 after four idle chars
// - receive buffer read clears timeout
// - tx empty 0010: empty or at threshold
// - tx clears: ident read, write, above threshold
// - threshold mode enabled by enable bit 7
// - threshold mode: irq at or below threshold
// - threshold from fifo control bits 5:4
// - threshold mode: status bit5 means full
// - fifo enable off disables threshold mode
// - otherwise irq and bit5 mean empty
`ifndef UART_IRQ_REGS_VH
`define UART_IRQ_REGS_VH
`define OFS_RX_BUF 8'h00
`define OFS_TX_HOLD 8'h00
`define OFS_IRQ_EN 8'h04
`define OFS_IDENT 8'h08
`define OFS_FIFO_CTRL 8'h08
`define OFS_LINE_STAT 8'h14
`define OFS_CHAR_TIME 8'h40
`define IEN_RX 0
`define IEN_TX 1
`define IEN_LINE 2
`define IEN_THR_MODE 7
`define FCR_FIFO_EN 0
`define FCR_TX_THR_LO 4
`define FCR_TX_THR_HI 5
`define FCR_RX_TRIG_LO 6
`define FCR_RX_TRIG_HI 7
`define LSR_TX_BIT 5
`define ID_NONE 4'h1
`define ID_LINE 4'h6
`define ID_RX 4'h4
`define ID_TIMEOUT 4'hc
`define ID_TX 4'h2
`define FIFO_DEPTH 5'h10
`define TIMEOUT_CHARS 3'h4
`define CHAR_TIME_RST 16'h0010
`endif
